//--- verilog/omc_pkg.sv
// Shared constants and types of the operating mode controller.
package omc_pkg;
  // Register byte addresses.
  localparam logic [11:0] OMC_A_MODE = 12'h000;
  localparam logic [11:0] OMC_A_WDT = 12'h004;
  localparam logic [11:0] OMC_A_STAT = 12'h008;
  localparam logic [11:0] OMC_A_IST = 12'h00C;
  localparam logic [11:0] OMC_A_IMSK = 12'h010;
  // Field positions of the system mode register.
  localparam int OMC_B_HL = 0;
  localparam int OMC_B_DIV = 1;
  localparam int OMC_B_IDLE = 4;
  localparam int OMC_B_LRDY = 5;
  localparam int OMC_B_HRDY = 6;
  localparam int OMC_B_PAW = 8;
  // Field positions of the watchdog control register.
  localparam int OMC_B_WEN = 0;
  localparam int OMC_B_WSUB = 1;
  localparam int OMC_B_WSEL = 2;
  localparam int OMC_B_KEEP = 5;
  localparam int OMC_B_VDET = 6;
  // Field positions of the status register.
  localparam int OMC_B_PDN = 0;
  localparam int OMC_B_TO = 1;
  localparam int OMC_B_WCLR = 2;
  // Event bits of the interrupt status and mask registers.
  localparam int OMC_E_HALT = 0;
  localparam int OMC_E_WAKE = 1;
  localparam int OMC_E_WOVF = 2;
  localparam int OMC_E_HRDY = 3;
  localparam int OMC_NEV = 4;
  localparam int OMC_PA_W = 8;
  // Reset values.
  localparam logic OMC_RST_HL = 1'b1;
  localparam logic [2:0] OMC_RST_DIV = 3'h0;
  localparam logic OMC_RST_WEN = 1'b1;
  localparam logic [2:0] OMC_RST_WSEL = 3'h7;
  // Timing counts and limits.
  localparam int OMC_HOSC_XTAL_CYC = 1024;
  localparam int OMC_HOSC_RC_CYC = 16;
  localparam logic [2:0] OMC_SLOW_DIV_MAX = 3'h1;
  localparam logic [15:0] OMC_WDT_MIN = 16'h0100;

  // Operating modes of the controller.
  typedef enum logic [2:0] {
    OMC_NORMAL = 3'b000,
    OMC_SLOW = 3'b001,
    OMC_SLEEP_ALL_STOPPED = 3'b010,
    OMC_SLEEP_SUB_RUNNING = 3'b011,
    OMC_IDLE_SUB_ONLY = 3'b100,
    OMC_IDLE_SYSCLK_ON = 3'b101,
    OMC_HWAIT = 3'b110
  } omc_mode_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } omc_apb_req_t;

  // APB answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } omc_apb_rsp_t;

  // Clock gate outputs towards the clock tree.
  typedef struct packed {
    logic sys_en;
    logic tb_en;
    logic sub_en;
    logic wdt_clk_en;
    logic hosc_en;
    logic hdiv_en;
    logic use_low;
  } omc_clk_t;
endpackage

//--- verilog/omc_ctrl.sv
// Operating mode controller: clock selection, low power modes and watchdog.
//
// Operation
// RULE1: Low clock with divider 000/001 gives slow.
// RULE2: Low clock stops high source and dividers.
// RULE3: Slow entered only with low oscillator ready; a wake from halt returns to slow without checking it.
// RULE4: High select or divider 010-111 gives normal.
// RULE5: High oscillator ready flag readable; software checks.
// RULE6: Halt, no idle, watchdog/detector off: deepest sleep.
// RULE7: Deepest sleep clears and stops watchdog.
// RULE8: Halt, no idle, watchdog/detector on: sub sleep.
// RULE9: Sub sleep clears watchdog, counts on sub clock.
// RULE10: Halt, idle, no keep: first idle mode.
// RULE11: First idle: sub watchdog runs, system one stops.
// RULE12: Halt, idle, keep: second idle, clocks run.
// RULE13: Second idle: watchdog cleared, runs either source.
// RULE14: Halt stops execution, state kept.
// RULE15: Halt sets power-down, clears timeout flag.
// RULE16: High ready cleared, rises after wait count.
// RULE17: Wake on port fall, interrupt, watchdog.
// RULE18: Keep old clock until high oscillator ready.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module omc_ctrl #(
  parameter int HOSC_WAIT = omc_pkg::OMC_HOSC_XTAL_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire omc_pkg::omc_apb_req_t apb_req,
  output omc_pkg::omc_apb_rsp_t apb_rsp,
  input wire logic halt_req,
  input wire logic low_osc_stable,
  input wire logic sub_tick,
  input wire logic [omc_pkg::OMC_PA_W-1:0] port_a_in,
  input wire logic sys_irq_req,
  output omc_pkg::omc_clk_t clk_gate,
  output logic cpu_halted,
  output logic wdt_reset,
  output logic irq,
  output omc_pkg::omc_mode_t mode
);
  import omc_pkg::*;

  // The wait counter is eleven bits wide.
  if (HOSC_WAIT < 1 || HOSC_WAIT > 2047) begin : g_chk
    $error("HOSC_WAIT must lie between 1 and 2047");
  end

  localparam logic [10:0] HW_LAST = 11'(HOSC_WAIT - 1);

  // Whole state of the controller.
  typedef struct packed {
    omc_mode_t mode;
    logic run_low;
    logic hl;
    logic [2:0] div;
    logic idle_en;
    logic [OMC_PA_W-1:0] pa_wen;
    logic wdt_en;
    logic wdt_sub;
    logic [2:0] wdt_sel;
    logic keep_sys;
    logic vdet_en;
    logic pwr_dn;
    logic to;
    logic [OMC_NEV-1:0] ist;
    logic [OMC_NEV-1:0] imsk;
    logic [10:0] hcnt;
    logic hrdy;
    logic lrdy;
    logic [15:0] wcnt;
    logic [OMC_PA_W-1:0] pa_prev;
    logic wdt_rst;
    logic halted;
    logic irq;
    omc_clk_t ck;
    omc_apb_rsp_t rsp;
  } omc_st_t;

  omc_st_t st_r; // Registered state.
  omc_st_t st_nxt; // Next state.
  logic want_slow; // Software asks for the low clock.
  logic run; // CPU is executing.
  logic lp; // A sleep or idle mode is active.
  logic wtick; // Watchdog counts this cycle.
  logic wovf; // Watchdog overflows this cycle.
  logic wake; // A wake-up source fired.
  logic hclr; // Halt entry clears the watchdog.
  logic wclr; // Software clears the watchdog.
  logic wr; // APB write takes effect.
  logic [15:0] wlim; // Last watchdog count before overflow.
  logic [OMC_NEV-1:0] ev; // Events of this cycle.
  logic [OMC_NEV-1:0] iclr; // Status bits cleared by software.

  // Next state of the whole controller.
  always_comb begin
    st_nxt = st_r;
    ev = '0;
    iclr = '0;
    wclr = 1'b0;
    hclr = 1'b0;
    st_nxt.pa_prev = port_a_in;
    st_nxt.lrdy = low_osc_stable;
    want_slow = !st_r.hl && (st_r.div <= OMC_SLOW_DIV_MAX); // [RULE1] [RULE4]
    run = (st_r.mode == OMC_NORMAL) || (st_r.mode == OMC_SLOW);
    lp = !run && (st_r.mode != OMC_HWAIT);
    wlim = 16'(OMC_WDT_MIN << st_r.wdt_sel) - 16'h0001;
    // Watchdog ticks only from a running source clock.
    wtick = st_r.wdt_en && (st_r.wdt_sub ? (sub_tick && st_r.ck.sub_en) : st_r.ck.sys_en);
    wovf = wtick && (st_r.wcnt == wlim);
    wake = (|(st_r.pa_prev & ~port_a_in & st_r.pa_wen)) || sys_irq_req || wovf; // [RULE17]

    // APB answers one cycle after setup, so access has no wait state.
    wr = apb_req.psel && apb_req.penable && st_r.rsp.pready && apb_req.pwrite;
    st_nxt.rsp.pready = apb_req.psel && !apb_req.penable;
    st_nxt.rsp.prdata = '0;
    st_nxt.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      case (apb_req.paddr)
        OMC_A_MODE: begin
          st_nxt.rsp.prdata[OMC_B_HL] = st_r.hl;
          st_nxt.rsp.prdata[OMC_B_DIV +: 3] = st_r.div;
          st_nxt.rsp.prdata[OMC_B_IDLE] = st_r.idle_en;
          st_nxt.rsp.prdata[OMC_B_LRDY] = st_r.lrdy; // [RULE3]
          st_nxt.rsp.prdata[OMC_B_HRDY] = st_r.hrdy; // [RULE5]
          st_nxt.rsp.prdata[OMC_B_PAW +: OMC_PA_W] = st_r.pa_wen;
        end
        OMC_A_WDT: begin
          st_nxt.rsp.prdata[OMC_B_WEN] = st_r.wdt_en;
          st_nxt.rsp.prdata[OMC_B_WSUB] = st_r.wdt_sub;
          st_nxt.rsp.prdata[OMC_B_WSEL +: 3] = st_r.wdt_sel;
          st_nxt.rsp.prdata[OMC_B_KEEP] = st_r.keep_sys;
          st_nxt.rsp.prdata[OMC_B_VDET] = st_r.vdet_en;
        end
        OMC_A_STAT: begin
          st_nxt.rsp.prdata[OMC_B_PDN] = st_r.pwr_dn;
          st_nxt.rsp.prdata[OMC_B_TO] = st_r.to;
        end
        OMC_A_IST: begin
          st_nxt.rsp.prdata[OMC_NEV-1:0] = st_r.ist;
        end
        OMC_A_IMSK: begin
          st_nxt.rsp.prdata[OMC_NEV-1:0] = st_r.imsk;
        end
        default: begin
          st_nxt.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // Register writes at the access edge.
    if (wr) begin
      case (apb_req.paddr)
        OMC_A_MODE: begin
          st_nxt.hl = apb_req.pwdata[OMC_B_HL];
          st_nxt.div = apb_req.pwdata[OMC_B_DIV +: 3];
          st_nxt.idle_en = apb_req.pwdata[OMC_B_IDLE];
          st_nxt.pa_wen = apb_req.pwdata[OMC_B_PAW +: OMC_PA_W];
        end
        OMC_A_WDT: begin
          st_nxt.wdt_en = apb_req.pwdata[OMC_B_WEN];
          st_nxt.wdt_sub = apb_req.pwdata[OMC_B_WSUB];
          st_nxt.wdt_sel = apb_req.pwdata[OMC_B_WSEL +: 3];
          st_nxt.keep_sys = apb_req.pwdata[OMC_B_KEEP];
          st_nxt.vdet_en = apb_req.pwdata[OMC_B_VDET];
        end
        OMC_A_STAT: begin
          // Writing the clear bit acts like the clear-watchdog instruction.
          wclr = apb_req.pwdata[OMC_B_WCLR];
          if (wclr) begin
            st_nxt.pwr_dn = 1'b0;
            st_nxt.to = 1'b0;
          end
        end
        OMC_A_IST: begin
          iclr = apb_req.pwdata[OMC_NEV-1:0];
        end
        OMC_A_IMSK: begin
          st_nxt.imsk = apb_req.pwdata[OMC_NEV-1:0];
        end
        default: begin
          st_nxt.imsk = st_r.imsk;
        end
      endcase
    end

    // Operating mode sequence.
    case (st_r.mode)
      OMC_NORMAL, OMC_SLOW: begin
        if (halt_req) begin
          hclr = 1'b1;
          st_nxt.run_low = (st_r.mode == OMC_SLOW);
          st_nxt.pwr_dn = 1'b1; // [RULE15]
          st_nxt.to = 1'b0; // [RULE15]
          ev[OMC_E_HALT] = 1'b1;
          if (!st_r.idle_en && !st_r.wdt_en && !st_r.vdet_en) begin
            st_nxt.mode = OMC_SLEEP_ALL_STOPPED; // [RULE6]
          end else if (!st_r.idle_en) begin
            st_nxt.mode = OMC_SLEEP_SUB_RUNNING; // [RULE8]
          end else if (!st_r.keep_sys) begin
            st_nxt.mode = OMC_IDLE_SUB_ONLY; // [RULE10]
          end else begin
            st_nxt.mode = OMC_IDLE_SYSCLK_ON; // [RULE12]
          end
        end else if (st_r.mode == OMC_NORMAL && want_slow && st_r.lrdy) begin
          st_nxt.mode = OMC_SLOW; // [RULE1] [RULE3]
        end else if (st_r.mode == OMC_SLOW && !want_slow && st_r.hrdy) begin
          st_nxt.mode = OMC_NORMAL; // [RULE4] [RULE18]
        end
      end
      OMC_SLEEP_ALL_STOPPED, OMC_SLEEP_SUB_RUNNING, OMC_IDLE_SUB_ONLY,
      OMC_IDLE_SYSCLK_ON: begin
        // Return to the clock that ran before the halt.
        if (wake) begin
          ev[OMC_E_WAKE] = 1'b1;
          if (st_r.run_low) begin
            st_nxt.mode = OMC_SLOW;
          end else if (st_r.hrdy) begin
            st_nxt.mode = OMC_NORMAL;
          end else begin
            st_nxt.mode = OMC_HWAIT; // [RULE16]
          end
        end
      end
      OMC_HWAIT: begin
        // Execution resumes only once the high oscillator is stable.
        if (st_r.hrdy) begin
          st_nxt.mode = OMC_NORMAL;
        end
      end
      default: begin
        st_nxt.mode = OMC_NORMAL;
      end
    endcase

    // Watchdog counter, cleared at halt entry and then gated by its clock.
    if (hclr || wclr || wovf) begin
      st_nxt.wcnt = '0; // [RULE7] [RULE9] [RULE11] [RULE13]
    end else if (wtick) begin
      st_nxt.wcnt = st_r.wcnt + 16'h0001;
    end
    st_nxt.wdt_rst = wovf;
    if (wovf) begin
      st_nxt.to = 1'b1;
      ev[OMC_E_WOVF] = 1'b1;
    end

    // High oscillator wait counter; the flag drops while the source is off.
    if (!st_r.ck.hosc_en) begin
      st_nxt.hcnt = '0;
      st_nxt.hrdy = 1'b0; // [RULE16]
    end else if (!st_r.hrdy) begin
      if (st_r.hcnt == HW_LAST) begin
        st_nxt.hrdy = 1'b1; // [RULE5] [RULE16]
        ev[OMC_E_HRDY] = 1'b1;
      end else begin
        st_nxt.hcnt = st_r.hcnt + 11'h001;
      end
    end

    // Clock gates follow the next mode so they switch with it.
    st_nxt.ck = '0;
    case (st_nxt.mode)
      OMC_NORMAL: begin
        st_nxt.ck.sys_en = 1'b1;
        st_nxt.ck.tb_en = 1'b1;
        st_nxt.ck.sub_en = 1'b1;
        st_nxt.ck.hosc_en = 1'b1;
      end
      OMC_SLOW: begin
        st_nxt.ck.sys_en = 1'b1;
        st_nxt.ck.tb_en = 1'b1;
        st_nxt.ck.sub_en = 1'b1;
        st_nxt.ck.use_low = 1'b1; // [RULE18]
        // High source starts only when a return to normal is pending.
        st_nxt.ck.hosc_en = !(!st_nxt.hl && (st_nxt.div <= OMC_SLOW_DIV_MAX)); // [RULE2]
      end
      OMC_SLEEP_SUB_RUNNING: begin
        st_nxt.ck.sub_en = 1'b1; // [RULE8]
        st_nxt.ck.use_low = st_nxt.run_low;
      end
      OMC_IDLE_SUB_ONLY: begin
        st_nxt.ck.tb_en = 1'b1; // [RULE10]
        st_nxt.ck.sub_en = 1'b1;
        st_nxt.ck.use_low = st_nxt.run_low;
      end
      OMC_IDLE_SYSCLK_ON: begin
        st_nxt.ck.sys_en = 1'b1; // [RULE12]
        st_nxt.ck.tb_en = 1'b1;
        st_nxt.ck.sub_en = 1'b1;
        st_nxt.ck.use_low = st_nxt.run_low;
        st_nxt.ck.hosc_en = !st_nxt.run_low;
      end
      OMC_HWAIT: begin
        st_nxt.ck.sub_en = 1'b1;
        st_nxt.ck.hosc_en = 1'b1;
      end
      default: begin
        st_nxt.ck.use_low = st_nxt.run_low; // [RULE6]
      end
    endcase
    st_nxt.ck.hdiv_en = st_nxt.ck.hosc_en; // [RULE2]
    st_nxt.ck.wdt_clk_en = st_nxt.wdt_en &&
        (st_nxt.wdt_sub ? st_nxt.ck.sub_en : st_nxt.ck.sys_en); // [RULE7] [RULE11]
    st_nxt.halted = (st_nxt.mode != OMC_NORMAL) && (st_nxt.mode != OMC_SLOW); // [RULE14]

    // Sticky events; a new event wins over a clear in the same cycle.
    st_nxt.ist = (st_r.ist & ~iclr) | ev;
    st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
  end

  // State register.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.mode <= OMC_NORMAL;
      st_r.hl <= OMC_RST_HL;
      st_r.div <= OMC_RST_DIV;
      st_r.wdt_en <= OMC_RST_WEN;
      st_r.wdt_sel <= OMC_RST_WSEL;
      st_r.pa_prev <= '1;
      st_r.ck.sys_en <= 1'b1;
      st_r.ck.tb_en <= 1'b1;
      st_r.ck.sub_en <= 1'b1;
      st_r.ck.hosc_en <= 1'b1;
      st_r.ck.hdiv_en <= 1'b1;
      st_r.ck.wdt_clk_en <= OMC_RST_WEN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign apb_rsp = st_r.rsp;
  assign clk_gate = st_r.ck;
  assign cpu_halted = st_r.halted;
  assign wdt_reset = st_r.wdt_rst;
  assign irq = st_r.irq;
  assign mode = st_r.mode;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Slow mode is reached from normal only with the low oscillator reported stable.
  AST_SLOW_LRDY: assert property ( // [RULE3]
    (st_r.mode == OMC_NORMAL) ##1 (st_r.mode == OMC_SLOW) |-> $past(st_r.lrdy))
    else $error("slow mode entered before low oscillator ready");
  // A settled slow mode keeps the high source and dividers off.
  AST_SLOW_HOFF: assert property ( // [RULE2]
    (st_r.mode == OMC_SLOW && want_slow && !halt_req && !wr) |=>
      (!st_r.ck.hosc_en && !st_r.ck.hdiv_en && st_r.ck.use_low))
    else $error("high source runs in settled slow mode");
  // Return to normal happens only after the ready flag.
  AST_BACK_HRDY: assert property ( // [RULE18]
    (st_r.mode == OMC_SLOW) ##1 (st_r.mode == OMC_NORMAL) |-> $past(st_r.hrdy))
    else $error("normal mode entered before high oscillator ready");
  // Deepest sleep stops system, time base and watchdog clocks.
  AST_SLEEP_ALL_STOPPED: assert property ( // [RULE6]
    (run && halt_req && !st_r.idle_en && !st_r.wdt_en && !st_r.vdet_en) |=>
      (st_r.mode == OMC_SLEEP_ALL_STOPPED && !st_r.ck.sys_en && !st_r.ck.tb_en &&
       !st_r.ck.wdt_clk_en && st_r.halted))
    else $error("deepest sleep not entered correctly");
  // Watchdog counter stays clear throughout deepest sleep.
  AST_SLEEP_ALL_STOPPED_WDT: assert property ( // [RULE7]
    (st_r.mode == OMC_SLEEP_ALL_STOPPED) |-> (st_r.wcnt == 16'h0000))
    else $error("watchdog not cleared in deepest sleep");
  // Sub sleep keeps only the sub clock.
  AST_SLEEP_SUB_RUNNING: assert property ( // [RULE8]
    (run && halt_req && !st_r.idle_en && (st_r.wdt_en || st_r.vdet_en)) |=>
      (st_r.mode == OMC_SLEEP_SUB_RUNNING && !st_r.ck.sys_en && !st_r.ck.tb_en &&
       st_r.ck.sub_en))
    else $error("sub sleep not entered correctly");
  // First idle stops the system clock and high source, keeping time base and sub clocks.
  AST_IDLE_SUB_ONLY: assert property ( // [RULE10]
    (run && halt_req && st_r.idle_en && !st_r.keep_sys) |=>
      (st_r.mode == OMC_IDLE_SUB_ONLY && !st_r.ck.sys_en && st_r.ck.tb_en && st_r.ck.sub_en))
    else $error("first idle not entered correctly");
  // Second idle keeps the system, time base and sub clocks.
  AST_IDLE_SYSCLK_ON: assert property ( // [RULE12]
    (run && halt_req && st_r.idle_en && st_r.keep_sys) |=>
      (st_r.mode == OMC_IDLE_SYSCLK_ON && st_r.ck.sys_en && st_r.ck.tb_en && st_r.ck.sub_en))
    else $error("second idle not entered correctly");
  // Halt entry sets power down and clears timeout and counter.
  AST_HALT_FLAGS: assert property ( // [RULE15]
    (run && halt_req && !wovf) |=> (st_r.pwr_dn && !st_r.to && st_r.wcnt == 16'h0000))
    else $error("halt flags wrong");
  // Ready flag rises exactly after the full wait count.
  AST_HRDY_WAIT: assert property ( // [RULE16]
    $rose(st_r.hrdy) |-> ($past(st_r.hcnt) == HW_LAST && $past(st_r.ck.hosc_en)))
    else $error("high ready flag timing wrong");
  // An interrupt request ends any sleep or idle mode next cycle.
  AST_WAKE: assert property ( // [RULE17]
    (lp && sys_irq_req) |=> !(st_r.mode inside {OMC_SLEEP_ALL_STOPPED,
      OMC_SLEEP_SUB_RUNNING, OMC_IDLE_SUB_ONLY, OMC_IDLE_SYSCLK_ON}))
    else $error("wake-up missed");
endmodule
`default_nettype wire

//--- bench/omc_cpu_model.sv
// Behavioural CPU core, sub clock and low oscillator facing the mode controller.
`timescale 1ns/100ps
`default_nettype none
module omc_cpu_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic halt_cmd,
  input wire logic lo_ok,
  input wire logic cpu_halted,
  output logic halt_req,
  output logic low_osc_stable,
  output logic sub_tick
);
  logic [1:0] tick_cnt; // Divides the system clock down to the sub clock rate.

  // A halted core executes nothing, so it can only issue halt while running.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      halt_req <= 1'b0;
      tick_cnt <= 2'h0;
    end else begin
      halt_req <= halt_cmd & ~cpu_halted;
      tick_cnt <= tick_cnt + 2'h1;
    end
  end

  // One sub clock tick every four system clocks.
  assign sub_tick = (tick_cnt == 2'h3);
  // The low oscillator reports stable only when the bench lets it.
  assign low_osc_stable = lo_ok;
endmodule
`default_nettype wire

//--- bench/operating_mode_controller_tb_top.sv
// Self-checking bench of the operating mode controller.
`timescale 1ns/100ps
`default_nettype none
module operating_mode_controller_tb_top;
  import omc_pkg::*;
  localparam int HW = 16; // Short high oscillator wait keeps the run brief.
  logic clk_sys, sys_rst, halt_cmd, lo_ok, halt_req, low_osc_stable, sub_tick;
  logic sys_irq_req, cpu_halted, wdt_reset, irq, rd_err;
  logic [7:0] port_a_in;
  logic [31:0] rd_data;
  omc_apb_req_t apb_req;
  omc_apb_rsp_t apb_rsp;
  omc_clk_t clk_gate;
  omc_mode_t mode;
  int n_errors, tests_run;
  int cyc = 0; // Cycle count for the hang guard.
  int n_wrst = 0; // Watchdog reset pulses seen so far.

  omc_ctrl #(.HOSC_WAIT(HW)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .halt_req(halt_req), .low_osc_stable(low_osc_stable),
    .sub_tick(sub_tick), .port_a_in(port_a_in), .sys_irq_req(sys_irq_req),
    .clk_gate(clk_gate), .cpu_halted(cpu_halted), .wdt_reset(wdt_reset), .irq(irq),
    .mode(mode));
  omc_cpu_model cpu_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .halt_cmd(halt_cmd),
    .lo_ok(lo_ok), .cpu_halted(cpu_halted), .halt_req(halt_req),
    .low_osc_stable(low_osc_stable), .sub_tick(sub_tick));

  // Free-running 50 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Prints the counts and the verdict, then stops.
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang is cut short well after the tests should have ended.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // Each watchdog overflow pulse is counted for the checks.
    if (wdt_reset === 1'b1) begin
      n_wrst <= n_wrst + 1;
    end
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle edge behind it.
  task automatic apb(input logic is_wr, input logic [11:0] addr, input logic [31:0] wdata);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= is_wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wdata;
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer.
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rd_data = apb_rsp.prdata;
    rd_err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Register write.
  task automatic wr(input logic [11:0] addr, input logic [31:0] d);
    apb(1'b1, addr, d);
  endtask

  // Register read compared with an expected word.
  task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(rd_data, exp);
  endtask

  // Waits, bounded, until the controller shows the wanted mode.
  task automatic wait_mode(input omc_mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(mode), 32'(m));
  endtask

  // Halt into one low power mode, check gates and flags, then wake by the given source.
  task automatic hcase(input logic [31:0] mw, input logic [31:0] ww, input omc_mode_t m,
                       input logic [3:0] g, input int wk);
    wr(OMC_A_WDT, ww);
    wr(OMC_A_MODE, mw);
    wr(OMC_A_STAT, 32'h4);
    halt_cmd <= 1'b1;
    @(posedge clk_sys);
    halt_cmd <= 1'b0;
    wait_mode(m, 10);
    chk({28'h0, clk_gate.sys_en, clk_gate.tb_en, clk_gate.sub_en, clk_gate.wdt_clk_en},
        {28'h0, g});
    chk({30'h0, cpu_halted, irq}, 32'h3);
    rd(OMC_A_STAT, 32'h1);
    // Source 1 is a port pin falling, 0 an interrupt request, 2 the watchdog itself.
    if (wk == 1) begin
      port_a_in <= 8'hFE;
    end else if (wk == 0) begin
      sys_irq_req <= 1'b1;
    end
    wait_mode(OMC_NORMAL, 2000);
    chk({31'h0, cpu_halted}, 32'h0);
    port_a_in <= 8'hFF;
    sys_irq_req <= 1'b0;
    if (wk == 2) begin
      rd(OMC_A_STAT, 32'h3);
      chk(32'(n_wrst), 32'h1);
    end
  endtask

  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    halt_cmd = 1'b0;
    lo_ok = 1'b1;
    port_a_in = 8'hFF;
    sys_irq_req = 1'b0;
    apb_req = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (HW + 6) @(posedge clk_sys);
    rd(OMC_A_MODE, 32'h0000_0061);
    rd(OMC_A_WDT, 32'h0000_001D);
    rd(OMC_A_STAT, 32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    chk(rd_data, 32'h0);
    // Slow mode waits for the low oscillator, then drops the high source.
    lo_ok <= 1'b0;
    wr(OMC_A_MODE, 32'h0000_0002);
    repeat (6) @(posedge clk_sys);
    chk(32'(mode), 32'(OMC_NORMAL));
    lo_ok <= 1'b1;
    wait_mode(OMC_SLOW, 20);
    chk({29'h0, clk_gate.use_low, clk_gate.hosc_en, clk_gate.hdiv_en}, 32'h4);
    // Divider 010 returns to normal, but only after the high oscillator is ready.
    wr(OMC_A_MODE, 32'h0000_0004);
    repeat (3) @(posedge clk_sys);
    chk({30'h0, clk_gate.use_low, clk_gate.hosc_en}, 32'h3);
    wait_mode(OMC_NORMAL, HW + 20);
    rd(OMC_A_MODE, 32'h0000_0064);
    wr(OMC_A_IMSK, 32'h1);
    hcase(32'h001, 32'h1C, OMC_SLEEP_ALL_STOPPED, 4'h0, 0);
    hcase(32'h001, 32'h03, OMC_SLEEP_SUB_RUNNING, 4'h3, 2);
    hcase(32'h111, 32'h03, OMC_IDLE_SUB_ONLY, 4'h7, 1);
    hcase(32'h111, 32'h01, OMC_IDLE_SUB_ONLY, 4'h6, 1);
    hcase(32'h011, 32'h23, OMC_IDLE_SYSCLK_ON, 4'hF, 0);
    hcase(32'h011, 32'h21, OMC_IDLE_SYSCLK_ON, 4'hF, 0);
    // Halt from slow with only the voltage detector on; wake returns to the low clock.
    wr(OMC_A_WDT, 32'h40);
    wr(OMC_A_MODE, 32'h0);
    wait_mode(OMC_SLOW, 20);
    halt_cmd <= 1'b1;
    @(posedge clk_sys);
    halt_cmd <= 1'b0;
    wait_mode(OMC_SLEEP_SUB_RUNNING, 10);
    chk({27'h0, clk_gate.use_low, clk_gate.sys_en, clk_gate.tb_en, clk_gate.sub_en,
         clk_gate.wdt_clk_en}, 32'h12);
    sys_irq_req <= 1'b1;
    wait_mode(OMC_SLOW, 10);
    sys_irq_req <= 1'b0;
    wr(OMC_A_MODE, 32'h1);
    wait_mode(OMC_NORMAL, HW + 20);
    wr(OMC_A_WDT, 32'h0);
    // Masking, then clearing, takes the interrupt line down.
    wr(OMC_A_IMSK, 32'h0);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(OMC_A_IMSK, 32'hF);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(OMC_A_IST, 32'hF);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(OMC_A_IST, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
